// [src/sbu_consts.svh]
// Constants of the skip and branch unit: widths, flag positions, cycles.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SBU_CONSTS_SVH
`define SBU_CONSTS_SVH

// Datapath widths
`define SBU_PC_W      16
`define SBU_OFS_W     7
`define SBU_CYC_W     2

// Status-register layout
`define SBU_FLAG_C    3'h0
`define SBU_FLAG_Z    3'h1
`define SBU_FLAG_N    3'h2

// Cycle counts
`define SBU_CYC_ONE   2'h1
`define SBU_CYC_TWO   2'h2
`define SBU_CYC_THREE 2'h3

// Program-counter steps in words
`define SBU_STEP_ONE  2'h1
`define SBU_STEP_TWO  2'h2
`define SBU_STEP_THR  2'h3

`endif

// [src/sbu_pkg.sv]
// Types of the skip and branch unit.
// Assumes sbu_consts.svh on the include path.
`include "sbu_consts.svh"

package sbu_pkg;

    // Instruction selected by the decoder
    typedef enum logic [3:0] {
        SKIP_IF_REG_BIT_CLEAR,
        SKIP_IF_REG_BIT_SET,
        SKIP_IF_IO_BIT_CLEAR,
        SKIP_IF_IO_BIT_SET,
        BRANCH_FLAG_SET,
        BRANCH_FLAG_CLEAR,
        BRANCH_EQUAL,
        BRANCH_NOT_EQUAL,
        BRANCH_CARRY_SET,
        BRANCH_CARRY_CLEAR,
        BRANCH_SAME_OR_HIGHER,
        BRANCH_LOWER,
        BRANCH_MINUS,
        BRANCH_PLUS
    } sbu_op_type;

    // One request from the decoder
    typedef struct packed {
        sbu_op_type                 op;
        logic [2:0]                 bit_sel;
        logic [7:0]                 reg_data;
        logic [7:0]                 io_data;
        logic [7:0]                 status_register;
        logic [`SBU_OFS_W-1:0]      offset;
        logic [`SBU_PC_W-1:0]       pc;
        logic                       next_two_word;
    } sbu_req_type;

    // One answer to the fetch logic
    typedef struct packed {
        logic [`SBU_PC_W-1:0]       next_pc;
        logic [`SBU_CYC_W-1:0]      cycles;
        logic                       taken;
    } sbu_res_type;

endpackage : sbu_pkg

// [src/sbu_top.sv]
// Skip and branch unit: next program counter and cycle count for the
// bit-test skips and the conditional relative branches.
// Assumes the decoder presents a request only while busy_o is low and
// that status flags are written by no one else for these instructions.
// A request seen while busy_o is high is dropped without an answer,
// so the decoder must hold it until busy_o falls.
// Skip length relies on the decoder's next_two_word hint; this block
// never looks at the following instruction itself.
`timescale 1ns/1ps
`include "sbu_consts.svh"

module sbu_top (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_b_i,
    // Request from the decoder
    input  wire logic                 req_valid_i,
    input  wire sbu_pkg::sbu_req_type req_i,
    // Answer to the fetch logic
    output logic                      res_valid_o,
    output sbu_pkg::sbu_res_type      res_o,
    output logic                      busy_o,
    output logic                      flags_we_o,
    output logic [7:0]                status_o
);

    import sbu_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helper functions

    // One bit out of a byte, chosen by a 3-bit index
    function automatic logic pick_bit(
        input logic [7:0] data,
        input logic [2:0] sel
    );
        pick_bit = data[sel];
    endfunction : pick_bit

    // Program counter plus a small unsigned step
    function automatic logic [`SBU_PC_W-1:0] pc_step(
        input logic [`SBU_PC_W-1:0] pc,
        input logic [1:0]           step
    );
        logic [`SBU_PC_W-1:0] wide;
        wide = {{(`SBU_PC_W-2){1'b0}}, step};
        pc_step = pc + wide;
    endfunction : pc_step

    ////////////////////////////////////////////////////////////////////
    // Control state

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_HOLD
    } sbu_state_type;

    sbu_state_type          state_q;
    sbu_state_type          state_d;
    logic [`SBU_CYC_W-1:0]  count_q;
    logic [`SBU_CYC_W-1:0]  count_d;
    logic                   valid_q;
    logic                   busy_q;
    logic                   busy_d;
    sbu_res_type            res_q;
    sbu_res_type            res_d;
    logic [7:0]             status_q;
    logic                   flags_we_q;

    ////////////////////////////////////////////////////////////////////
    // Operand selection

    wire logic                  accept;
    wire logic                  reg_bit;
    wire logic                  io_bit;
    wire logic                  sel_flag;
    wire logic                  flag_c;
    wire logic                  flag_z;
    wire logic                  flag_n;

    // Requests during a multi-cycle hold are ignored
    assign accept   = req_valid_i && (state_q == ST_IDLE);
    assign reg_bit  = pick_bit(req_i.reg_data, req_i.bit_sel);
    assign io_bit   = pick_bit(req_i.io_data, req_i.bit_sel);
    assign sel_flag = pick_bit(req_i.status_register, req_i.bit_sel);
    assign flag_c   = pick_bit(req_i.status_register, `SBU_FLAG_C);
    assign flag_z   = pick_bit(req_i.status_register, `SBU_FLAG_Z);
    assign flag_n   = pick_bit(req_i.status_register, `SBU_FLAG_N);

    ////////////////////////////////////////////////////////////////////
    // Skip conditions

    wire logic skip_rc;
    wire logic skip_rs;
    wire logic skip_ic;
    wire logic skip_is;
    wire logic is_skip;
    wire logic skip_hit;

    // Each skip form tests its own operand bit
    assign skip_rc = (req_i.op == SKIP_IF_REG_BIT_CLEAR)
                  && !reg_bit;
    assign skip_rs = (req_i.op == SKIP_IF_REG_BIT_SET)
                  && reg_bit;
    assign skip_ic = (req_i.op == SKIP_IF_IO_BIT_CLEAR)
                  && !io_bit;
    assign skip_is = (req_i.op == SKIP_IF_IO_BIT_SET)
                  && io_bit;

    // Any of the four skip forms, taken or not
    assign is_skip = (req_i.op == SKIP_IF_REG_BIT_CLEAR)
                  || (req_i.op == SKIP_IF_REG_BIT_SET)
                  || (req_i.op == SKIP_IF_IO_BIT_CLEAR)
                  || (req_i.op == SKIP_IF_IO_BIT_SET);
    assign skip_hit = skip_rc || skip_rs || skip_ic || skip_is;

    ////////////////////////////////////////////////////////////////////
    // Branch conditions

    wire logic br_fs;
    wire logic br_fc;
    wire logic br_eq;
    wire logic br_ne;
    wire logic br_cs;
    wire logic br_cc;
    wire logic br_mi;
    wire logic br_pl;
    wire logic br_hit;

    // Generic forms test the flag picked by bit_sel
    assign br_fs = (req_i.op == BRANCH_FLAG_SET) && sel_flag;
    assign br_fc = (req_i.op == BRANCH_FLAG_CLEAR) && !sel_flag;
    assign br_eq = (req_i.op == BRANCH_EQUAL) && flag_z;
    assign br_ne = (req_i.op == BRANCH_NOT_EQUAL) && !flag_z;
    // Lower is an alias of carry set
    assign br_cs = ((req_i.op == BRANCH_CARRY_SET)
                 || (req_i.op == BRANCH_LOWER)) && flag_c;
    // Same-or-higher is an alias of carry clear
    assign br_cc = ((req_i.op == BRANCH_CARRY_CLEAR)
                 || (req_i.op == BRANCH_SAME_OR_HIGHER))
                 && !flag_c;
    assign br_mi = (req_i.op == BRANCH_MINUS) && flag_n;
    assign br_pl = (req_i.op == BRANCH_PLUS) && !flag_n;

    // Taken when any branch form hits
    assign br_hit = br_fs || br_fc || br_eq || br_ne
                 || br_cs || br_cc || br_mi || br_pl;

    ////////////////////////////////////////////////////////////////////
    // Target arithmetic

    wire logic [`SBU_PC_W-1:0] ofs_ext;
    wire logic [`SBU_PC_W-1:0] pc_next;
    wire logic [`SBU_PC_W-1:0] pc_branch;
    wire logic [`SBU_PC_W-1:0] pc_skip;
    wire logic [1:0]           skip_step;

    // Sign extension lets a backward loop wrap the counter
    assign ofs_ext = {{(`SBU_PC_W-`SBU_OFS_W){req_i.offset[`SBU_OFS_W-1]}},
                      req_i.offset};
    assign pc_next   = pc_step(req_i.pc, `SBU_STEP_ONE);
    assign pc_branch = pc_next + ofs_ext;
    // Two-word successor needs one more word of advance
    assign skip_step = req_i.next_two_word ? `SBU_STEP_THR
                                           : `SBU_STEP_TWO;
    assign pc_skip   = pc_step(req_i.pc, skip_step);

    ////////////////////////////////////////////////////////////////////
    // Answer selection

    wire logic [`SBU_CYC_W-1:0] cyc_skip;
    wire logic [`SBU_CYC_W-1:0] cyc_br;
    wire logic [`SBU_CYC_W-1:0] cyc_sel;
    wire logic                  hit;

    // Cycle count grows with the length of the skipped word
    assign cyc_skip = !skip_hit           ? `SBU_CYC_ONE
                    : req_i.next_two_word ? `SBU_CYC_THREE
                                          : `SBU_CYC_TWO;
    assign cyc_br   = br_hit ? `SBU_CYC_TWO : `SBU_CYC_ONE;
    assign cyc_sel  = is_skip ? cyc_skip : cyc_br;
    assign hit      = is_skip ? skip_hit : br_hit;

    // Untaken cases fall through to the next word
    always_comb begin
        res_d = res_q;
        if (accept) begin
            res_d.taken  = hit;
            res_d.cycles = cyc_sel;
            if (!hit) begin
                res_d.next_pc = pc_next;
            end else if (is_skip) begin
                res_d.next_pc = pc_skip;
            end else begin
                res_d.next_pc = pc_branch;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Hold sequencing

    // Holds the core for the extra cycles of taken cases
    // A refused request leaves the answer registers untouched
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        busy_d  = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept && (cyc_sel != `SBU_CYC_ONE)) begin
                    state_d = ST_HOLD;
                    count_d = cyc_sel - `SBU_CYC_ONE;
                    busy_d  = 1'b1;
                end
            end
            ST_HOLD: begin
                count_d = count_q - `SBU_CYC_ONE;
                if (count_q == `SBU_CYC_ONE) begin
                    state_d = ST_IDLE;
                end else begin
                    busy_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
                count_d = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    // Sequencer state
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
            count_q <= '0;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            busy_q  <= busy_d;
        end
    end

    // Answer registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_q <= 1'b0;
            res_q   <= '0;
        end else begin
            valid_q <= accept;
            res_q   <= res_d;
        end
    end

    // Flags pass through untouched by either group
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_q <= '0;
        end else if (accept) begin
            status_q <= req_i.status_register;
        end
    end

    // Flag write strobe, a flop so that every output is registered
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_we_q <= 1'b0;
        end else begin
            flags_we_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign res_valid_o = valid_q;
    assign res_o       = res_q;
    assign busy_o      = busy_q;
    assign flags_we_o  = flags_we_q;
    assign status_o    = status_q;

endmodule : sbu_top

// [bench/sbu_top_sva.sv]
// Port checker of the skip and branch unit.
// Assumes sbu_pkg compiled first; bound onto sbu_top.
`timescale 1ns/1ps
`include "sbu_consts.svh"
module sbu_top_sva
    import sbu_pkg::*;
(
    // Clock and reset
    input wire logic                 clk_sys_i,
    input wire logic                 rst_b_i,
    // Watched ports
    input wire logic                 req_valid_i,
    input wire sbu_pkg::sbu_req_type req_i,
    input wire logic                 res_valid_o,
    input wire sbu_pkg::sbu_res_type res_o,
    input wire logic                 busy_o,
    input wire logic                 flags_we_o,
    input wire logic [7:0]           status_o
);
    logic        take_w;
    logic        skip_w;
    logic [15:0] sext_w;
    sbu_req_type req_q;

    // Accepted request, kept to judge its answer
    assign take_w = req_valid_i && !busy_o;
    assign skip_w = req_q.op <= SKIP_IF_IO_BIT_SET;
    assign sext_w = {{9{req_q.offset[6]}}, req_q.offset};
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i)
            req_q <= '0;
        else if (take_w)
            req_q <= req_i;
    end

    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    a_answer_next: assert property (take_w |=> res_valid_o)
        else $error("answer missing after accept");
    a_no_stray: assert property (res_valid_o |-> $past(take_w))
        else $error("answer without request");
    a_one_idle: assert property (res_valid_o && res_o.cycles == 2'h1
        |-> !busy_o) else $error("busy after one-cycle op");
    a_two_hold: assert property (res_valid_o && res_o.cycles == 2'h2
        |-> busy_o ##1 !busy_o) else $error("two-cycle hold wrong");
    a_three_hold: assert property (
        res_valid_o && res_o.cycles == 2'h3 |-> busy_o [*2] ##1 !busy_o)
        else $error("three-cycle hold wrong");
    a_untaken_step: assert property (res_valid_o && !res_o.taken
        |-> res_o.next_pc == req_q.pc + 16'h1 && res_o.cycles == 2'h1)
        else $error("fall-through pc wrong");
    a_skip_step: assert property (
        res_valid_o && res_o.taken && skip_w
        |-> res_o.next_pc == req_q.pc + (req_q.next_two_word ? 16'h3 : 16'h2))
        else $error("skip pc wrong");
    a_branch_target: assert property (
        res_valid_o && res_o.taken && !skip_w
        |-> res_o.next_pc == req_q.pc + 16'h1 + sext_w && res_o.cycles == 2'h2)
        else $error("branch target wrong");
    a_equal_zero: assert property (
        res_valid_o && req_q.op == BRANCH_EQUAL
        |-> res_o.taken == req_q.status_register[`SBU_FLAG_Z])
        else $error("equal branch condition wrong");
    a_lower_carry: assert property (
        res_valid_o && req_q.op == BRANCH_LOWER
        |-> res_o.taken == req_q.status_register[`SBU_FLAG_C])
        else $error("lower branch condition wrong");
    a_flags_quiet: assert property (!flags_we_o)
        else $error("flag write seen");

    // Main scenarios
    c_branch: cover property (res_valid_o && res_o.taken && !skip_w);
    c_long_skip: cover property (res_valid_o && res_o.cycles == 2'h3);
    c_refused: cover property (req_valid_i && busy_o);
endmodule : sbu_top_sva

bind sbu_top sbu_top_sva i_sva (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .res_valid_o(res_valid_o),
    .res_o(res_o), .busy_o(busy_o), .flags_we_o(flags_we_o),
    .status_o(status_o));

// [bench/skip_and_branch_unit_test.sv]
// Self-checking bench of the skip and branch unit.
// Assumes sbu_pkg and sbu_top compiled; stimulus at falling edges.
`timescale 1ns/1ps
`include "sbu_consts.svh"
`define CHK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("BAD %s exp %h got %h", what, exp, got); \
        end \
    end
module skip_and_branch_unit_test;
    import sbu_pkg::*;
    typedef struct packed {sbu_res_type r; logic [7:0] s;} sbu_exp_type;
    logic        clk_sys_i = 1'b0;
    logic        rst_b_i;
    logic        req_valid_i;
    sbu_req_type req_i;
    logic        res_valid_o;
    sbu_res_type res_o;
    logic        busy_o;
    logic        flags_we_o;
    logic [7:0]  status_o;
    sbu_exp_type exp_q[$];
    sbu_exp_type cur;
    sbu_req_type r;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          busy_left = 0;

    sbu_top i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .res_valid_o(res_valid_o),
        .res_o(res_o), .busy_o(busy_o), .flags_we_o(flags_we_o),
        .status_o(status_o));

    // 250 MHz core clock
    always #2 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////
    // Reference answer worked out from the instruction's condition
    function automatic sbu_res_type exp_res(input sbu_req_type q);
        logic        t;
        logic [7:0]  s;
        sbu_res_type e;
        s = q.status_register;
        case (q.op)
            SKIP_IF_REG_BIT_CLEAR: t = !q.reg_data[q.bit_sel];
            SKIP_IF_REG_BIT_SET:   t = q.reg_data[q.bit_sel];
            SKIP_IF_IO_BIT_CLEAR:  t = !q.io_data[q.bit_sel];
            SKIP_IF_IO_BIT_SET:    t = q.io_data[q.bit_sel];
            BRANCH_FLAG_SET:       t = s[q.bit_sel];
            BRANCH_FLAG_CLEAR:     t = !s[q.bit_sel];
            BRANCH_EQUAL:          t = s[`SBU_FLAG_Z];
            BRANCH_NOT_EQUAL:      t = !s[`SBU_FLAG_Z];
            BRANCH_CARRY_SET,
            BRANCH_LOWER:          t = s[`SBU_FLAG_C];
            BRANCH_CARRY_CLEAR:    t = !s[`SBU_FLAG_C];
            BRANCH_SAME_OR_HIGHER: t = !s[`SBU_FLAG_C];
            BRANCH_MINUS:          t = s[`SBU_FLAG_N];
            default:               t = !s[`SBU_FLAG_N];
        endcase
        e.taken   = t;
        e.next_pc = q.pc + 16'h1;
        e.cycles  = `SBU_CYC_ONE;
        if (t && q.op <= SKIP_IF_IO_BIT_SET) begin
            e.next_pc = q.pc + (q.next_two_word ? 16'h3 : 16'h2);
            e.cycles  = q.next_two_word ? `SBU_CYC_THREE : `SBU_CYC_TWO;
        end else if (t) begin
            e.next_pc = q.pc + 16'h1
                      + {{9{q.offset[6]}}, q.offset};
            e.cycles  = `SBU_CYC_TWO;
        end
        return e;
    endfunction : exp_res

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // A busy unit drops the request, so no answer is noted for it
    task automatic drive(input sbu_req_type q, input bit hold);
        int k;
        k = 0;
        @(negedge clk_sys_i);
        while (hold && busy_o !== 1'b0 && k < 4) begin
            req_valid_i = 1'b0;
            @(negedge clk_sys_i);
            k++;
        end
        if (k == 4) begin
            n_fail++;
            stop_test();
        end
        req_valid_i = 1'b1;
        req_i       = q;
        if (busy_o !== 1'b1)
            exp_q.push_back('{exp_res(q), q.status_register});
    endtask : drive

    task automatic drain();
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        for (int k = 0; k < 8 && exp_q.size() != 0; k++)
            @(negedge clk_sys_i);
        `CHK("drained", 0, exp_q.size())
    endtask : drain

    // Each answer is matched against the oldest note
    always @(negedge clk_sys_i) begin
        if (res_valid_o === 1'b1) begin
            if (exp_q.size() == 0)
                `CHK("stray answer", 1'b0, 1'b1)
            else begin
                cur = exp_q.pop_front();
                `CHK("result", cur.r, res_o)
                `CHK("status", cur.s, status_o)
                `CHK("flag write", 1'b0, flags_we_o)
                busy_left = cur.r.cycles - 1;
            end
        end
        // Hold length follows the expected cycle count, not busy_o
        if (rst_b_i === 1'b1) begin
            `CHK("busy", busy_left != 0, busy_o)
            if (busy_left != 0)
                busy_left--;
        end else
            busy_left = 0;
    end

    initial begin
        void'($urandom(40));
        rst_b_i     = 1'b0;
        req_valid_i = 1'b0;
        req_i       = '0;
        repeat (10) @(posedge clk_sys_i);
        @(negedge clk_sys_i) rst_b_i = 1'b1;
        // Every op, taken and not, boundary offsets, pc wrap
        for (int i = 0; i < 56; i++) begin
            r    = '0;
            r.op = sbu_op_type'(i % 14);
            r.bit_sel = 3'(i);
            {r.reg_data, r.io_data, r.status_register} =
                ((i / 14) % 2 == 1) ? '1 : '0;
            r.offset  = i[1] ? 7'h40 : 7'h3f;
            r.pc      = i[2] ? 16'hffff : 16'h0010;
            r.next_two_word = i[3];
            drive(r, 1'b1);
        end
        // Random traffic, back to back, refusals while busy
        for (int i = 0; i < 400; i++) begin
            r    = sbu_req_type'(55'({$urandom, $urandom}));
            r.op = sbu_op_type'($urandom_range(13));
            drive(r, 1'b1 && ($urandom_range(3) == 0));
        end
        drain();
        // Reset in the middle of a three-cycle skip
        r    = '0;
        r.op = SKIP_IF_REG_BIT_CLEAR;
        r.next_two_word = 1'b1;
        drive(r, 1'b1);
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        // Answer checked above; reset lands in the second hold cycle
        @(negedge clk_sys_i);
        rst_b_i     = 1'b0;
        exp_q.delete();
        @(negedge clk_sys_i);
        `CHK("reset", 29'h0, {res_valid_o, res_o, busy_o, status_o})
        rst_b_i = 1'b1;
        // Taken equal branch backwards by two
        r    = '0;
        r.op = BRANCH_EQUAL;
        r.pc = 16'h0010;
        r.offset = 7'h7e;
        r.status_register = 8'h02;
        drive(r, 1'b1);
        drain();
        stop_test();
    end
endmodule : skip_and_branch_unit_test
